/* core/gpcn_top.sv */
// ports b..f with direction, pin and latch registers, plus change notify
// assumes an APB master on pclk and pad inputs synchronous to pclk
//
// Notes on behaviour
// RULE1: an irq is raised when any selected change input changes level.
// RULE2: a change while the clock is stopped is still seen once it runs again.
// RULE3: 22 change inputs 0..21, each with its own enable bit.
// RULE4: direction bit one makes the pin an input, zero an output.
// RULE5: software waits one cycle after a direction or latch write before reading pins.
// RULE6: port b has bits 5..0, direction resets to 0x003f.
// RULE7: port c has bits 15..13, direction resets to 0xe000.
// RULE8: port d has bits 1..0 (direction reset 0x0007), port f bits 3..2 (0x000c).
// RULE9: port e has bits 8 and 5..0, direction resets to 0x013f.
// RULE10: latch reads give the latch, pin reads the pins, writes to either load the latch.
// RULE11: unimplemented bits read as zero in every port register.
// RULE12: an enabled input differing from its stored level sets a sticky flag.
// RULE13: pin and latch registers reset to zero.
//
// Chosen here: the APB register port.
`include "gpcn_consts.svh"
`timescale 1ns/1ps

module gpcn_top (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [`GPCN_AW-1:0]               paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic [`GPCN_NPORT-1:0][15:0]      pad_in,
    output gpcn_pkg::gpcn_pad_drv_t [`GPCN_NPORT-1:0] pad_drv,
    input  wire logic [`GPCN_NCN-1:0]              cn_in,
    output logic                                   cn_irq
);

    localparam int NP = `GPCN_NPORT;
    localparam int NC = `GPCN_NCN;

    // RULE6: port b implemented bits
    // RULE7: port c implemented bits
    // RULE8: ports d and f implemented bits
    // RULE9: port e implemented bits
    localparam logic [NP-1:0][15:0] IMPL = {
        `GPCN_IMPL_F, `GPCN_IMPL_E, `GPCN_IMPL_D,
        `GPCN_IMPL_C, `GPCN_IMPL_B
    };
    localparam logic [NP-1:0][15:0] DIR_RST = {
        `GPCN_DIR_RST_F, `GPCN_DIR_RST_E, `GPCN_DIR_RST_D,
        `GPCN_DIR_RST_C, `GPCN_DIR_RST_B
    };

    function automatic gpcn_pkg::gpcn_dec_t gpcn_decode(
        input logic [`GPCN_AW-1:0] a
    );
        gpcn_pkg::gpcn_dec_t d;
        d        = '0;
        d.hit    = (a[1:0] == 2'h0);
        unique case (a[`GPCN_AW-1:2])
            `GPCN_IDX_B_DIR: d.kind = gpcn_pkg::GPCN_K_DIR;
            `GPCN_IDX_B_PIN: d.kind = gpcn_pkg::GPCN_K_PIN;
            `GPCN_IDX_B_LAT: d.kind = gpcn_pkg::GPCN_K_LAT;
            `GPCN_IDX_C_DIR: begin
                d.port = 3'h1;
                d.kind = gpcn_pkg::GPCN_K_DIR;
            end
            `GPCN_IDX_C_PIN: begin
                d.port = 3'h1;
                d.kind = gpcn_pkg::GPCN_K_PIN;
            end
            `GPCN_IDX_C_LAT: begin
                d.port = 3'h1;
                d.kind = gpcn_pkg::GPCN_K_LAT;
            end
            `GPCN_IDX_D_DIR: begin
                d.port = 3'h2;
                d.kind = gpcn_pkg::GPCN_K_DIR;
            end
            `GPCN_IDX_D_PIN: begin
                d.port = 3'h2;
                d.kind = gpcn_pkg::GPCN_K_PIN;
            end
            `GPCN_IDX_D_LAT: begin
                d.port = 3'h2;
                d.kind = gpcn_pkg::GPCN_K_LAT;
            end
            `GPCN_IDX_E_DIR: begin
                d.port = 3'h3;
                d.kind = gpcn_pkg::GPCN_K_DIR;
            end
            `GPCN_IDX_E_PIN: begin
                d.port = 3'h3;
                d.kind = gpcn_pkg::GPCN_K_PIN;
            end
            `GPCN_IDX_E_LAT: begin
                d.port = 3'h3;
                d.kind = gpcn_pkg::GPCN_K_LAT;
            end
            `GPCN_IDX_F_DIR: begin
                d.port = 3'h4;
                d.kind = gpcn_pkg::GPCN_K_DIR;
            end
            `GPCN_IDX_F_PIN: begin
                d.port = 3'h4;
                d.kind = gpcn_pkg::GPCN_K_PIN;
            end
            `GPCN_IDX_F_LAT: begin
                d.port = 3'h4;
                d.kind = gpcn_pkg::GPCN_K_LAT;
            end
            `GPCN_IDX_CN_EN: begin
                d.kind   = gpcn_pkg::GPCN_K_CN;
                d.cn_sel = 2'h0;
            end
            `GPCN_IDX_CN_ST: begin
                d.kind   = gpcn_pkg::GPCN_K_CN;
                d.cn_sel = 2'h1;
            end
            `GPCN_IDX_CN_MK: begin
                d.kind   = gpcn_pkg::GPCN_K_CN;
                d.cn_sel = 2'h2;
            end
            default: d.hit = 1'b0;
        endcase
        return d;
    endfunction

    // bus side
    logic                   pready_ff;
    logic                   pslverr_ff;
    logic [31:0]            prdata_ff;
    gpcn_pkg::gpcn_dec_t    dec;
    wire                    setup_ph = psel & ~penable;
    wire                    wr_take  = psel & penable & pready_ff & pwrite;
    wire                    wr_hit   = wr_take & dec.hit;

    // low address bits must be zero, otherwise the access is refused
    assign dec = gpcn_decode(paddr);

    // port state
    logic [NP-1:0][15:0]    dir_ff;
    logic [NP-1:0][15:0]    lat_ff;
    logic [NP-1:0][15:0]    pin_ff;
    logic [NP-1:0][15:0]    oe_ff;
    logic [NP-1:0][15:0]    nxt_dir;
    logic [NP-1:0][15:0]    nxt_lat;
    logic [NP-1:0][15:0]    dir_rd;
    logic [NP-1:0][15:0]    lat_rd;

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            wire sel_p  = wr_hit & (dec.port == 3'(p));
            wire wr_dir = sel_p & (dec.kind == gpcn_pkg::GPCN_K_DIR);
            // RULE10: pin writes land in the latch
            wire wr_lat = sel_p & ((dec.kind == gpcn_pkg::GPCN_K_LAT) |
                                   (dec.kind == gpcn_pkg::GPCN_K_PIN));

            // unimplemented direction bits keep their reset value
            assign nxt_dir[p] = wr_dir ? ((pwdata[15:0] & IMPL[p]) |
                                          (dir_ff[p] & ~IMPL[p])) : dir_ff[p];
            assign nxt_lat[p] = wr_lat ? (pwdata[15:0] & IMPL[p]) : lat_ff[p];
            // RULE11: unimplemented bits read zero
            assign dir_rd[p]  = dir_ff[p] & IMPL[p];
            assign lat_rd[p]  = lat_ff[p] & IMPL[p];

            // RULE13: pin and latch reset clear
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dir_ff[p] <= DIR_RST[p];
                    lat_ff[p] <= `GPCN_LAT_RST;
                    pin_ff[p] <= `GPCN_PIN_RST;
                    oe_ff[p]  <= IMPL[p] & ~DIR_RST[p];
                end else begin
                    dir_ff[p] <= nxt_dir[p];
                    lat_ff[p] <= nxt_lat[p];
                    // RULE5: pins sampled one cycle late
                    pin_ff[p] <= pad_in[p] & IMPL[p];
                    // RULE4: zero drives, one listens
                    oe_ff[p]  <= IMPL[p] & ~nxt_dir[p];
                end
            end

            assign pad_drv[p].out = lat_ff[p];
            assign pad_drv[p].oe  = oe_ff[p];
        end
    endgenerate

    // change notify state
    logic [NC-1:0]          cn_en_ff;
    logic [NC-1:0]          cn_st_ff;
    logic [NC-1:0]          cn_mk_ff;
    logic [NC-1:0]          cn_ref_ff;
    logic                   irq_ff;
    logic [NC-1:0]          nxt_cn_st;
    logic [NC-1:0]          nxt_cn_mk;
    wire                    wr_cn    = wr_hit & (dec.kind == gpcn_pkg::GPCN_K_CN);
    wire                    wr_cn_en = wr_cn & (dec.cn_sel == 2'h0);
    wire                    wr_cn_st = wr_cn & (dec.cn_sel == 2'h1);
    wire                    wr_cn_mk = wr_cn & (dec.cn_sel == 2'h2);

    // RULE2: plain level compare, so a change while the clock is
    // stopped stays visible against the frozen reference
    // RULE12: enabled mismatch against stored level
    // RULE3: only enabled inputs count
    wire [NC-1:0]           cn_evt   = (cn_in ^ cn_ref_ff) & cn_en_ff;
    // a clear write only touches the bits written as one
    wire [NC-1:0]           cn_clr   = wr_cn_st ? pwdata[NC-1:0] : '0;

    // set wins over a same-cycle clear
    assign nxt_cn_st = (cn_st_ff & ~cn_clr) | cn_evt;

    // mask looks ahead like the flags, so irq never lags a mask write
    assign nxt_cn_mk = wr_cn_mk ? pwdata[NC-1:0] : cn_mk_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cn_en_ff  <= `GPCN_EN_RST;
            cn_mk_ff  <= `GPCN_MK_RST;
            cn_st_ff  <= `GPCN_ST_RST;
            cn_ref_ff <= '0;
        end else begin
            cn_en_ff  <= wr_cn_en ? pwdata[NC-1:0] : cn_en_ff;
            cn_mk_ff  <= nxt_cn_mk;
            cn_st_ff  <= nxt_cn_st;
            cn_ref_ff <= cn_in;
        end
    end

    // RULE1: level request while any unmasked flag stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_cn_st & nxt_cn_mk);
        end
    end

    // read selection, captured in the setup phase
    logic [15:0]            port_rd;
    logic [NC-1:0]          cn_rd;
    wire  [31:0]            rd_word;

    // RULE10: pin reads see the pads, latch reads the latch
    assign port_rd = (dec.kind == gpcn_pkg::GPCN_K_DIR) ? dir_rd[dec.port] :
                     (dec.kind == gpcn_pkg::GPCN_K_PIN) ? pin_ff[dec.port] :
                                                          lat_rd[dec.port];
    assign cn_rd   = (dec.cn_sel == 2'h0) ? cn_en_ff :
                     (dec.cn_sel == 2'h1) ? cn_st_ff : cn_mk_ff;
    assign rd_word = !dec.hit ? 32'h0000_0000 :
                     (dec.kind == gpcn_pkg::GPCN_K_CN) ? {10'h000, cn_rd} :
                                                         {16'h0000, port_rd};

    // one wait-free access: ready rises for the access phase only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup_ph;
            pslverr_ff <= setup_ph & ~dec.hit;
            prdata_ff  <= (setup_ph & ~pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign cn_irq  = irq_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    generate
        for (p = 0; p < NP; p++) begin : g_chk
            a_dir_drives_oe: assert property ( // RULE4
                pad_drv[p].oe == (IMPL[p] & ~dir_ff[p]))
                else $error("output enable does not follow direction");
            a_unimpl_reads_zero: assert property ( // RULE11
                ((pin_ff[p] | lat_ff[p] | oe_ff[p]) & ~IMPL[p]) == 16'h0000)
                else $error("unimplemented port bit is nonzero");
            a_pin_sample: assert property ( // RULE10
                ##1 pin_ff[p] == ($past(pad_in[p]) & IMPL[p]))
                else $error("pin register is not last cycle pad level");
            a_dir_write: assert property ( // RULE4
                g_port[p].wr_dir |=> dir_rd[p] == ($past(pwdata[15:0]) & IMPL[p]))
                else $error("direction write not held");
            a_dir_hold: assert property ( // RULE4
                !g_port[p].wr_dir |=> $stable(dir_ff[p]))
                else $error("direction changed without a write");
            a_lat_load: assert property ( // RULE10
                g_port[p].wr_lat |=> pad_drv[p].out == ($past(pwdata[15:0]) & IMPL[p]))
                else $error("latch or pin write not seen on the pad");
            a_lat_hold: assert property ( // RULE10
                !g_port[p].wr_lat |=> $stable(lat_ff[p]))
                else $error("latch changed without a write");
        end
    endgenerate

    a_lat_write: assert property ( // RULE10
        wr_hit & (dec.kind == gpcn_pkg::GPCN_K_LAT) & (dec.port == 3'h0)
        |=> pad_drv[0].out == ($past(pwdata[15:0]) & IMPL[0]))
        else $error("latch write not seen on port b output");
    a_evt_sets_flag: assert property ( // RULE12
        (|cn_evt) |=> ((cn_st_ff & $past(cn_evt)) == $past(cn_evt)))
        else $error("change event did not set its flag");
    a_disabled_quiet: assert property ( // RULE3
        ##1 ((cn_st_ff & ~$past(cn_st_ff) & ~$past(cn_en_ff)) == '0))
        else $error("disabled change input set a flag");
    a_irq_level: assert property ( // RULE1
        cn_irq == |(cn_st_ff & cn_mk_ff))
        else $error("irq does not match unmasked flags");
    a_flag_sticky: assert property ( // RULE12
        (|cn_st_ff) && !wr_cn_st |=> ((cn_st_ff & $past(cn_st_ff)) == $past(cn_st_ff)))
        else $error("flag fell without a clear");
    a_ready_pulse: assert property (
        setup_ph |=> pready ##1 !pready)
        else $error("ready not a one cycle answer");
    a_unmapped_err: assert property (
        setup_ph && !dec.hit |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped address not refused");

    a_refused_quiet: assert property (
        psel && penable && !dec.hit
        |=> $stable(dir_ff) && $stable(lat_ff) && $stable(cn_en_ff) && $stable(cn_mk_ff))
        else $error("refused access changed a register");
    a_idle_quiet: assert property (
        !pready |-> prdata == 32'h0000_0000 && !pslverr)
        else $error("read data or error outside the access phase");
    a_mapped_ok: assert property (
        setup_ph && dec.hit |=> !pslverr)
        else $error("mapped address answered with an error");
    a_ready_idle: assert property (
        !psel |=> !pready)
        else $error("ready raised with no request");

    a_dir_read: assert property ( // RULE11
        setup_ph && dec.hit && !pwrite && dec.kind == gpcn_pkg::GPCN_K_DIR
        |=> prdata == {16'h0000, $past(dir_rd[dec.port])})
        else $error("direction read differs from the register");
    a_pin_read: assert property ( // RULE10
        setup_ph && dec.hit && !pwrite && dec.kind == gpcn_pkg::GPCN_K_PIN
        |=> prdata == {16'h0000, $past(pin_ff[dec.port])})
        else $error("pin read differs from the sampled levels");
    a_lat_read: assert property ( // RULE10
        setup_ph && dec.hit && !pwrite && dec.kind == gpcn_pkg::GPCN_K_LAT
        |=> prdata == {16'h0000, $past(lat_rd[dec.port])})
        else $error("latch read differs from the latch");

    a_flag_clear: assert property ( // RULE12
        wr_cn_st |=> (cn_st_ff & $past(cn_clr) & ~$past(cn_evt)) == '0)
        else $error("written one did not clear its flag");
    a_flag_needs_evt: assert property ( // RULE12
        ##1 ((cn_st_ff & ~$past(cn_st_ff) & ~$past(cn_evt)) == '0))
        else $error("flag set without a change event");
    a_ref_follows: assert property ( // RULE12
        ##1 cn_ref_ff == $past(cn_in))
        else $error("change reference is not last cycle level");
    a_en_write: assert property ( // RULE3
        wr_cn_en |=> cn_en_ff == $past(pwdata[NC-1:0]))
        else $error("change enable write not held");
    a_mask_write: assert property ( // RULE1
        wr_cn_mk |=> cn_mk_ff == $past(pwdata[NC-1:0]))
        else $error("change mask write not held");

    c_irq_rise: cover property (!cn_irq ##1 cn_irq);
    c_flag_clear: cover property (wr_cn_st ##1 !cn_irq);
    c_dir_write: cover property (wr_hit && dec.kind == gpcn_pkg::GPCN_K_DIR);
    c_err_answer: cover property (pready && pslverr);
    c_pin_to_latch: cover property (wr_hit && dec.kind == gpcn_pkg::GPCN_K_PIN);

endmodule

/* core/gpcn_consts.svh */
// constants for the general purpose ports and change-notify block
// assumes a 12-bit APB byte address; register index = paddr[11:2]
`ifndef GPCN_CONSTS_SVH
`define GPCN_CONSTS_SVH

`define GPCN_AW        12
`define GPCN_IW        10
`define GPCN_NPORT     5
`define GPCN_PW        16
`define GPCN_NCN       22

// register indices, byte address = index * 4
`define GPCN_IDX_B_DIR 10'h2c6
`define GPCN_IDX_B_PIN 10'h2c8
`define GPCN_IDX_B_LAT 10'h2ca
`define GPCN_IDX_C_DIR 10'h2cc
`define GPCN_IDX_C_PIN 10'h2ce
`define GPCN_IDX_C_LAT 10'h2d0
`define GPCN_IDX_D_DIR 10'h2d2
`define GPCN_IDX_D_PIN 10'h2d4
`define GPCN_IDX_D_LAT 10'h2d6
`define GPCN_IDX_E_DIR 10'h2d8
`define GPCN_IDX_E_PIN 10'h2da
`define GPCN_IDX_E_LAT 10'h2dc
`define GPCN_IDX_F_DIR 10'h2de
`define GPCN_IDX_F_PIN 10'h2e0
`define GPCN_IDX_F_LAT 10'h2e2
`define GPCN_IDX_CN_EN 10'h2e4
`define GPCN_IDX_CN_ST 10'h2e6
`define GPCN_IDX_CN_MK 10'h2e8

// implemented bits of each port
`define GPCN_IMPL_B    16'h003f
`define GPCN_IMPL_C    16'he000
`define GPCN_IMPL_D    16'h0003
`define GPCN_IMPL_E    16'h013f
`define GPCN_IMPL_F    16'h000c

// direction reset values
`define GPCN_DIR_RST_B 16'h003f
`define GPCN_DIR_RST_C 16'he000
`define GPCN_DIR_RST_D 16'h0007
`define GPCN_DIR_RST_E 16'h013f
`define GPCN_DIR_RST_F 16'h000c

`define GPCN_PIN_RST   16'h0000
`define GPCN_LAT_RST   16'h0000
`define GPCN_EN_RST    22'h000000
`define GPCN_ST_RST    22'h000000
`define GPCN_MK_RST    22'h3fffff

`endif

/* core/gpcn_pkg.sv */
// types for the general purpose ports and change-notify block
// used by gpcn_top, gpcn_pads and the bench; constants live in gpcn_consts.svh
package gpcn_pkg;

    typedef enum logic [1:0] {
        GPCN_K_DIR,
        GPCN_K_PIN,
        GPCN_K_LAT,
        GPCN_K_CN
    } gpcn_kind_t;

    typedef struct packed {
        logic       hit;
        logic [2:0] port;
        gpcn_kind_t kind;
        logic [1:0] cn_sel;
    } gpcn_dec_t;

    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
    } gpcn_pad_drv_t;

endpackage

/* tb/gpcn_pads.sv */
// board side of the ports: pad cells and external levels
// assumes pad_drv from gpcn_top and board levels chosen by the bench
`timescale 1ns/1ps

module gpcn_pads (
    input  wire gpcn_pkg::gpcn_pad_drv_t [4:0] pad_drv,
    input  wire logic [4:0][15:0]              ext,
    output logic [4:0][15:0]                   pad_in
);
    // a driven pin shows its own output, an input pin the board level
    always_comb begin
        for (int p = 0; p < 5; p++) begin
            pad_in[p] = (pad_drv[p].out & pad_drv[p].oe) | (ext[p] & ~pad_drv[p].oe);
        end
    end
endmodule

/* tb/tb_gpio_ports_change_notify.sv */
// self-checking bench for the ports and change-notify block
// assumes gpcn_top, gpcn_pads and the consts header on the include path
`include "gpcn_consts.svh"
`timescale 1ns/1ps

module tb_gpio_ports_change_notify;
    localparam logic [15:0] IMPL [5] = '{16'h003f, 16'he000, 16'h0003, 16'h013f, 16'h000c};
    localparam logic [15:0] DRST [5] = '{16'h003f, 16'he000, 16'h0007, 16'h013f, 16'h000c};
    logic                          pclk;
    logic                          presetn;
    logic                          psel;
    logic                          penable;
    logic                          pwrite;
    logic [11:0]                   paddr;
    logic [31:0]                   pwdata;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
    logic [4:0][15:0]              pad_in;
    logic [4:0][15:0]              ext;
    gpcn_pkg::gpcn_pad_drv_t [4:0] pad_drv;
    logic [21:0]                   cn_in;
    logic                          cn_irq;
    logic                          clk_run;
    logic [31:0]                   rd;
    logic                          er;
    logic [31:0]                   seed;
    logic [15:0]                   d;
    logic [15:0]                   w;
    logic [21:0]                   e;
    logic [21:0]                   t;
    int                            failures;
    int                            n_checks;

    gpcn_top gpcn_top_i (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .pad_in  (pad_in),
        .pad_drv (pad_drv),
        .cn_in   (cn_in),
        .cn_irq  (cn_irq)
    );

    gpcn_pads gpcn_pads_i (
        .pad_drv (pad_drv),
        .ext     (ext),
        .pad_in  (pad_in)
    );

    // clk_run low freezes the clock, standing in for sleep
    initial begin
        pclk = 1'b0;
        forever #5 pclk = clk_run ? ~pclk : pclk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [9:0] ix(input int p, input int k);
        return 10'h2c6 + 10'(6 * p + 2 * k);
    endfunction

    task automatic end_sim();
        if (failures == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {a, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdc(input logic [9:0] a, input logic [31:0] exp, input logic xe);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, xe});
    endtask

    initial begin
        seed = 32'h27;
        failures = 0;
        n_checks = 0;
        clk_run = 1'b1;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cn_in = 22'h0;
        ext = '0;
        tick(3);
        presetn <= 1'b1;
        chk({31'h0, cn_irq}, 32'h0);
        for (int p = 0; p < 5; p++) begin
            chk({16'h0, pad_drv[p].oe}, 32'h0);
            rdc(ix(p, 0), {16'h0, DRST[p] & IMPL[p]}, 1'b0);
            rdc(ix(p, 1), 32'h0, 1'b0);
            rdc(ix(p, 2), 32'h0, 1'b0);
        end
        rdc(10'h2c7, 32'h0, 1'b1);
        rdc(`GPCN_IDX_CN_MK, 32'h003fffff, 1'b0);
        rdc(`GPCN_IDX_CN_ST, 32'h0, 1'b0);
        // first pass uses the 0xff00 direction example
        for (int it = 0; it < 4; it++) begin
            for (int p = 0; p < 5; p++) begin
                d = (it == 0) ? 16'hff00 : 16'(xs());
                w = 16'(xs());
                ext[p] <= 16'(xs());
                apb(1'b1, ix(p, 0), {16'h0, d});
                apb(1'b1, ix(p, (it % 2 == 1) ? 1 : 2), {16'h0, w});
                tick(2);
                chk({16'h0, pad_drv[p].oe}, {16'h0, IMPL[p] & ~d});
                chk({16'h0, pad_drv[p].out}, {16'h0, IMPL[p] & w});
                rdc(ix(p, 0), {16'h0, IMPL[p] & d}, 1'b0);
                rdc(ix(p, 2), {16'h0, IMPL[p] & w}, 1'b0);
                rdc(ix(p, 1), {16'h0, IMPL[p] & ((w & ~d) | (ext[p] & d))}, 1'b0);
            end
        end
        // first pass hits the end inputs 0 and 21 only
        for (int it = 0; it < 6; it++) begin
            e = (it == 0) ? 22'h200001 : 22'(xs());
            t = 22'(xs()) | 22'h200001;
            apb(1'b1, `GPCN_IDX_CN_EN, {10'h0, e});
            cn_in <= cn_in ^ t;
            tick(3);
            chk({31'h0, cn_irq}, {31'h0, |(e & t)});
            rdc(`GPCN_IDX_CN_ST, {10'h0, e & t}, 1'b0);
            apb(1'b1, `GPCN_IDX_CN_MK, 32'h0);
            tick(1);
            chk({31'h0, cn_irq}, 32'h0);
            rdc(`GPCN_IDX_CN_ST, {10'h0, e & t}, 1'b0);
            apb(1'b1, `GPCN_IDX_CN_ST, {10'h0, e & t});
            apb(1'b1, `GPCN_IDX_CN_MK, 32'h003fffff);
            rdc(`GPCN_IDX_CN_ST, 32'h0, 1'b0);
            chk({31'h0, cn_irq}, 32'h0);
        end
        // change made while the clock is frozen
        apb(1'b1, `GPCN_IDX_CN_EN, 32'h003fffff);
        @(negedge pclk);
        clk_run = 1'b0;
        #100;
        cn_in <= ~cn_in;
        #100;
        clk_run = 1'b1;
        tick(3);
        chk({31'h0, cn_irq}, 32'h1);
        rdc(`GPCN_IDX_CN_ST, 32'h003fffff, 1'b0);
        end_sim();
    end
endmodule
